// ==== serial_eeprom_data_memory.sv ====
// serial data memory: port register, instruction engine, self-timed cycle
//
// Functional notes
// - port bits: 0-3 zero, select, clock, in, out
// - array is 256 words of 8 bits
// - frame: start bit, two opcode, nine address bits
// - serial input sampled on serial clock rising edge
// - output active only while select high, else high
// - programming disabled after reset, enable required first
// - read gives zero dummy bit then 8 bits
// - read works whether programming enabled or not
// - read address auto-increments and wraps while selected
// - enable persists; disabled state ignores all programming
// - erase starts on select fall, self-timed
// - write starts on select fall, erase-before-write
// - output low while busy, high when done
// - erase-all sets whole array to ones
// - write-all copies data byte to every word
// - programming cycle ends within 2 ms
// - opcode and sub-code decoding
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_cfg.svh"

module serial_eeprom_data_memory #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       link_clk,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_bank,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata
);

  // ========================================================================
  // state and storage
  serial_eeprom_pkg::sys_state_t  st_r;
  serial_eeprom_pkg::sys_state_t  st_nxt;
  serial_eeprom_pkg::link_state_t lk_r;
  serial_eeprom_pkg::link_state_t lk_nxt;
  logic [7:0]                     mem [`MEM_WORDS];
  logic                           lrst_s1;
  logic                           lrst_s2;
  logic                           sclk_rise;
  logic                           sel_fall;
  logic                           do_vis;
  logic                           finish;
  logic [10:0]                    frame;

  function automatic logic port_hit(input logic [7:0] a, input logic b);
    port_hit = (a == `SMP_OFFSET) && (b == `SMP_BANK);
  endfunction

  assign reg_rdata = st_r.rdata;

  // ========================================================================
  // instruction engine
  always_comb
  begin
    st_nxt    = st_r;
    sclk_rise = st_r.port.sclk && !st_r.sclk_q;
    sel_fall  = st_r.sel_q && !st_r.port.sel;
    finish    = (st_r.state == serial_eeprom_pkg::ST_BUSY) && (st_r.done_s2 != st_r.done_q);
    frame     = {st_r.shift, st_r.port.sin};
    do_vis    = st_r.port.sel ? st_r.do_bit : 1'b1;
    st_nxt.sclk_q  = st_r.port.sclk;
    st_nxt.sel_q   = st_r.port.sel;
    st_nxt.done_s1 = lk_r.done_tgl;
    st_nxt.done_s2 = st_r.done_s1;
    st_nxt.done_q  = st_r.done_s2;
    if (reg_wr && port_hit(reg_addr, reg_bank))
    begin
      st_nxt.port.sel  = reg_wdata[`SMP_SEL_BIT];
      st_nxt.port.sclk = reg_wdata[`SMP_CLK_BIT];
      st_nxt.port.sin  = reg_wdata[`SMP_IN_BIT];
    end
    unique case (st_r.state)
      serial_eeprom_pkg::ST_IDLE:
      begin
        st_nxt.do_bit = 1'b1;
        if (st_r.port.sel && sclk_rise && st_r.port.sin)
        begin
          st_nxt.state = serial_eeprom_pkg::ST_SHIFT;
          st_nxt.cnt   = 4'h0;
        end
      end
      serial_eeprom_pkg::ST_SHIFT:
      begin
        if (sclk_rise)
        begin
          st_nxt.shift = {st_r.shift[8:0], st_r.port.sin};
          st_nxt.cnt   = st_r.cnt + 4'h1;
          if (st_r.cnt == `FRAME_LAST)
          begin
            st_nxt.addr  = frame[7:0];
            st_nxt.cnt   = 4'h0;
            st_nxt.state = serial_eeprom_pkg::ST_WAIT_CS;
            unique case (frame[10:9])
              `OP_READ:
              begin
                st_nxt.state  = serial_eeprom_pkg::ST_READ;
                st_nxt.rbyte  = mem[frame[7:0]];
                st_nxt.do_bit = 1'b0;
              end
              `OP_ERASE: st_nxt.pend = serial_eeprom_pkg::PEND_ERASE;
              `OP_WRITE:
              begin
                st_nxt.state = serial_eeprom_pkg::ST_DATA;
                st_nxt.pend  = serial_eeprom_pkg::PEND_WRITE;
              end
              `OP_EXT:
              begin
                unique case (frame[8:7])
                  `SUB_ENABLE:    st_nxt.en = 1'b1;
                  `SUB_DISABLE:   st_nxt.en = 1'b0;
                  `SUB_ERASE_ALL: st_nxt.pend = serial_eeprom_pkg::PEND_ERASE_ALL;
                  `SUB_WRITE_ALL:
                  begin
                    st_nxt.state = serial_eeprom_pkg::ST_DATA;
                    st_nxt.pend  = serial_eeprom_pkg::PEND_WRITE_ALL;
                  end
                endcase
              end
            endcase
          end
        end
      end
      serial_eeprom_pkg::ST_DATA:
      begin
        if (sclk_rise)
        begin
          st_nxt.wdata = {st_r.wdata[6:0], st_r.port.sin};
          st_nxt.cnt   = st_r.cnt + 4'h1;
          if (st_r.cnt == `BYTE_LAST)
          begin
            st_nxt.state = serial_eeprom_pkg::ST_WAIT_CS;
          end
        end
      end
      serial_eeprom_pkg::ST_READ:
      begin
        if (sclk_rise)
        begin
          st_nxt.do_bit = st_r.rbyte[7];
          st_nxt.rbyte  = {st_r.rbyte[6:0], 1'b0};
          st_nxt.cnt    = st_r.cnt + 4'h1;
          if (st_r.cnt == `BYTE_LAST)
          begin
            st_nxt.addr  = st_r.addr + 8'h01;
            st_nxt.rbyte = mem[8'(st_r.addr + 8'h01)];
            st_nxt.cnt   = 4'h0;
          end
        end
      end
      serial_eeprom_pkg::ST_WAIT_CS:
      begin
        st_nxt.do_bit = 1'b1;
      end
      serial_eeprom_pkg::ST_BUSY:
      begin
        st_nxt.do_bit = 1'b0;
        if (finish)
        begin
          st_nxt.state  = serial_eeprom_pkg::ST_IDLE;
          st_nxt.do_bit = 1'b1;
          st_nxt.pend   = serial_eeprom_pkg::PEND_NONE;
        end
      end
    endcase
    // select low ends any frame; a pending program cycle starts here
    if (!st_r.port.sel && st_r.state != serial_eeprom_pkg::ST_BUSY)
    begin
      st_nxt.state = serial_eeprom_pkg::ST_IDLE;
      st_nxt.pend  = serial_eeprom_pkg::PEND_NONE;
      if (sel_fall && st_r.state == serial_eeprom_pkg::ST_WAIT_CS &&
          st_r.pend != serial_eeprom_pkg::PEND_NONE && st_r.en)
      begin
        st_nxt.state     = serial_eeprom_pkg::ST_BUSY;
        st_nxt.pend      = st_r.pend;
        st_nxt.do_bit    = 1'b0;
        st_nxt.start_tgl = !st_r.start_tgl;
      end
    end
    st_nxt.rdata = (reg_wr || !port_hit(reg_addr, reg_bank)) ? st_r.rdata :
                   {do_vis, st_r.port.sin, st_r.port.sclk, st_r.port.sel, 4'h0};
    if (!port_hit(reg_addr, reg_bank))
      st_nxt.rdata = 8'h00;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_r        <= '0;
      st_r.state  <= serial_eeprom_pkg::ST_IDLE;
      st_r.pend   <= serial_eeprom_pkg::PEND_NONE;
      st_r.do_bit <= 1'b1;
      st_r.en     <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // ========================================================================
  // array update at the end of a self-timed cycle
  always_ff @(posedge sys_clk)
  begin
    if (finish)
    begin
      unique case (st_r.pend)
        serial_eeprom_pkg::PEND_ERASE:  mem[st_r.addr] <= `ERASED_BYTE;
        serial_eeprom_pkg::PEND_WRITE:  mem[st_r.addr] <= st_r.wdata;
        serial_eeprom_pkg::PEND_ERASE_ALL:
          for (int i = 0; i < `MEM_WORDS; i++)
            mem[i] <= `ERASED_BYTE;
        serial_eeprom_pkg::PEND_WRITE_ALL:
          for (int i = 0; i < `MEM_WORDS; i++)
            mem[i] <= st_r.wdata;
        default:
        begin
        end
      endcase
    end
  end

  // ========================================================================
  // self-timed generator on the link clock
  always_comb
  begin
    lk_nxt          = lk_r;
    lk_nxt.start_s1 = st_r.start_tgl;
    lk_nxt.start_s2 = lk_r.start_s1;
    lk_nxt.start_q  = lk_r.start_s2;
    if (lk_r.run)
    begin
      lk_nxt.cnt = lk_r.cnt - 32'd1;
      if (lk_r.cnt == 32'd0)
      begin
        lk_nxt.run      = 1'b0;
        lk_nxt.done_tgl = !lk_r.done_tgl;
      end
    end
    else if (lk_r.start_s2 != lk_r.start_q)
    begin
      lk_nxt.run = 1'b1;
      lk_nxt.cnt = 32'(PROG_CYCLES) - 32'd1;
    end
  end

  always_ff @(posedge link_clk)
  begin
    lrst_s1 <= sys_rst;
    lrst_s2 <= lrst_s1;
    if (lrst_s2)
      lk_r <= '0;
    else
      lk_r <= lk_nxt;
  end

  // ========================================================================
  // checks
  AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rdata[3:0] == 4'h0) else $error("reserved port bits not zero");

  AST_DO_HIGH_DESELECTED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!st_r.port.sel && !reg_wr && port_hit(reg_addr, reg_bank)) |=> reg_rdata[`SMP_OUT_BIT])
    else $error("output not high while deselected");

  AST_BUSY_LOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.state == serial_eeprom_pkg::ST_BUSY && st_r.port.sel && !finish) |-> !do_vis)
    else $error("output not low while busy");

  AST_DISABLED_AFTER_RESET: assert property (@(posedge sys_clk)
    $past(sys_rst) && !sys_rst |-> !st_r.en) else $error("enabled after reset");

  AST_NO_PROG_DISABLED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!st_r.en && st_r.state != serial_eeprom_pkg::ST_BUSY) |=>
    st_r.state != serial_eeprom_pkg::ST_BUSY) else $error("program cycle while disabled");

  AST_START_ON_FALL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.state == serial_eeprom_pkg::ST_WAIT_CS && sel_fall && st_r.en &&
     st_r.pend != serial_eeprom_pkg::PEND_NONE) |=>
    st_r.state == serial_eeprom_pkg::ST_BUSY && $changed(st_r.start_tgl))
    else $error("program cycle did not start");

  AST_READ_DUMMY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.state == serial_eeprom_pkg::ST_SHIFT && sclk_rise && st_r.cnt == `FRAME_LAST &&
     st_r.port.sel && frame[10:9] == `OP_READ) |=>
    (st_r.state == serial_eeprom_pkg::ST_READ && !st_r.do_bit))
    else $error("read dummy bit missing");

  AST_READ_INCREMENT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.state == serial_eeprom_pkg::ST_READ && st_r.port.sel && sclk_rise &&
     st_r.cnt == `BYTE_LAST) |=> st_r.addr == 8'($past(st_r.addr) + 8'h01))
    else $error("read address not incremented");

  AST_TIMER_END: assert property (@(posedge link_clk) disable iff (lrst_s2)
    (lk_r.run && lk_r.cnt == 32'd0) |=> (!lk_r.run && $changed(lk_r.done_tgl)))
    else $error("program timer did not finish");

  AST_TIMER_LOAD: assert property (@(posedge link_clk) disable iff (lrst_s2)
    (!lk_r.run && lk_r.start_s2 != lk_r.start_q) |=>
    (lk_r.run && lk_r.cnt == 32'(PROG_CYCLES) - 32'd1))
    else $error("program timer not loaded");

  AST_BUSY_HOLDS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.state == serial_eeprom_pkg::ST_BUSY && !finish) |=>
    st_r.state == serial_eeprom_pkg::ST_BUSY) else $error("busy cycle left early");

  AST_READY_AFTER_DONE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    finish |=> (st_r.state == serial_eeprom_pkg::ST_IDLE && st_r.do_bit))
    else $error("output not ready after cycle");

  AST_WRITE_LANDS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (finish && st_r.pend == serial_eeprom_pkg::PEND_WRITE) |=> mem[st_r.addr] == st_r.wdata)
    else $error("written word not stored");

  AST_ERASE_LANDS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (finish && st_r.pend == serial_eeprom_pkg::PEND_ERASE) |=> mem[st_r.addr] == `ERASED_BYTE)
    else $error("erased word not all ones");

  AST_WRITE_PENDS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.state == serial_eeprom_pkg::ST_SHIFT && sclk_rise && st_r.cnt == `FRAME_LAST &&
     st_r.port.sel && frame[10:9] == `OP_WRITE) |=>
    (st_r.state == serial_eeprom_pkg::ST_DATA && st_r.pend == serial_eeprom_pkg::PEND_WRITE))
    else $error("write opcode not decoded");

  AST_READ_SHIFT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.state == serial_eeprom_pkg::ST_READ && st_r.port.sel && sclk_rise) |=>
    st_r.do_bit == $past(st_r.rbyte[7])) else $error("read bit not shifted out");

  COV_READ: cover property (@(posedge sys_clk) disable iff (sys_rst)
    st_r.state == serial_eeprom_pkg::ST_READ && st_r.cnt == `BYTE_LAST && sclk_rise);
  COV_WRITE: cover property (@(posedge sys_clk) disable iff (sys_rst)
    finish && st_r.pend == serial_eeprom_pkg::PEND_WRITE);
  COV_ERASE_ALL: cover property (@(posedge sys_clk) disable iff (sys_rst)
    finish && st_r.pend == serial_eeprom_pkg::PEND_ERASE_ALL);
  COV_ERASE: cover property (@(posedge sys_clk) disable iff (sys_rst)
    finish && st_r.pend == serial_eeprom_pkg::PEND_ERASE);
  COV_WRITE_ALL: cover property (@(posedge sys_clk) disable iff (sys_rst)
    finish && st_r.pend == serial_eeprom_pkg::PEND_WRITE_ALL);

endmodule
`default_nettype wire

// ==== serial_eeprom_cfg.svh ====
// constants for the serial data memory port
`ifndef SERIAL_EEPROM_CFG_SVH
`define SERIAL_EEPROM_CFG_SVH

// ==========================================================================
// register placement
`define SMP_OFFSET        8'h40
`define SMP_BANK          1'b1
`define SMP_RESET         8'h80
// ==========================================================================
// field positions
`define SMP_SEL_BIT       4
`define SMP_CLK_BIT       5
`define SMP_IN_BIT        6
`define SMP_OUT_BIT       7
// ==========================================================================
// array and frame geometry
`define MEM_WORDS         256
`define FRAME_LAST        4'h0A
`define BYTE_LAST         4'h7
// ==========================================================================
// opcodes and opcode 00 sub-codes
`define OP_READ           2'h2
`define OP_ERASE          2'h3
`define OP_WRITE          2'h1
`define OP_EXT            2'h0
`define SUB_ENABLE        2'h3
`define SUB_DISABLE       2'h0
`define SUB_ERASE_ALL     2'h2
`define SUB_WRITE_ALL     2'h1
`define ERASED_BYTE       8'hFF
// ==========================================================================
// self-timed cycle, counted on the link clock
`define PROG_TIME_US      2000
`define LINK_CLK_KHZ      66667
`define PROG_CYCLES       ((`PROG_TIME_US * `LINK_CLK_KHZ) / 1000)

`endif

// ==== serial_eeprom_pkg.sv ====
// types for the serial data memory port
package serial_eeprom_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_DATA,
    ST_READ,
    ST_WAIT_CS,
    ST_BUSY
  } eep_state_t;

  typedef enum logic [2:0] {
    PEND_NONE,
    PEND_ERASE,
    PEND_WRITE,
    PEND_ERASE_ALL,
    PEND_WRITE_ALL
  } pend_t;

  typedef struct packed {
    logic sel;
    logic sclk;
    logic sin;
  } port_bits_t;

  typedef struct packed {
    eep_state_t  state;
    port_bits_t  port;
    logic        sclk_q;
    logic        sel_q;
    logic [9:0]  shift;
    logic [3:0]  cnt;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rbyte;
    logic        do_bit;
    logic        en;
    pend_t       pend;
    logic        start_tgl;
    logic        done_s1;
    logic        done_s2;
    logic        done_q;
    logic [7:0]  rdata;
  } sys_state_t;

  typedef struct packed {
    logic        start_s1;
    logic        start_s2;
    logic        start_q;
    logic        run;
    logic [31:0] cnt;
    logic        done_tgl;
  } link_state_t;

endpackage

// ==== serial_eeprom_fw.sv ====
// firmware model driving the serial memory port through register cycles
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_cfg.svh"

module serial_eeprom_fw (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_bank,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata
);
  // ==========================================================================
  // idle bus
  initial
  begin
    reg_addr  = `SMP_OFFSET;
    reg_bank  = `SMP_BANK;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
  end

  // ==========================================================================
  // port write, then a gap so every serial clock edge is seen
  task automatic pw(input logic sel, input logic sclk, input logic sin);
    @(negedge sys_clk);
    reg_addr  = `SMP_OFFSET;
    reg_bank  = `SMP_BANK;
    reg_wdata = {1'b0, sin, sclk, sel, 4'h0};
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    @(negedge sys_clk);
  endtask

  // read any address; data is registered one cycle later
  task automatic rd(input logic [7:0] a, input logic b, output logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_bank = b;
    @(negedge sys_clk);
    v        = reg_rdata;
    reg_addr = `SMP_OFFSET;
    reg_bank = `SMP_BANK;
  endtask

  task automatic bit_out(input logic b);
    pw(1'b1, 1'b0, b);
    pw(1'b1, 1'b1, b);
  endtask

  task automatic frame(input logic [1:0] op, input logic [8:0] a);
    logic [11:0] f;
    f = {1'b1, op, a};
    pw(1'b1, 1'b0, 1'b0);
    for (int i = 11; i >= 0; i--)
      bit_out(f[i]);
  endtask

  task automatic data_out(input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_out(d[i]);
  endtask

  // select low once ends every instruction
  task automatic deselect();
    pw(1'b0, 1'b0, 1'b1);
  endtask
endmodule
`default_nettype wire

// ==== tb_serial_eeprom_data_memory.sv ====
// self-checking bench for the serial data memory port
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_cfg.svh"

module tb_serial_eeprom_data_memory;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       link_clk = 1'b0;
  logic [7:0] reg_addr;
  logic       reg_bank;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] v;
  int         err_count = 0;
  int         n_checks = 0;

  always #25 sys_clk = ~sys_clk;
  initial
  begin
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  serial_eeprom_data_memory #(.PROG_CYCLES(20)) dut_u (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .link_clk  (link_clk),
    .reg_addr  (reg_addr),
    .reg_bank  (reg_bank),
    .reg_wr    (reg_wr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );

  serial_eeprom_fw fw_u (
    .sys_clk   (sys_clk),
    .reg_rdata (reg_rdata),
    .reg_addr  (reg_addr),
    .reg_bank  (reg_bank),
    .reg_wr    (reg_wr),
    .reg_wdata (reg_wdata)
  );

  // ==========================================================================
  // compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // one instruction, then status check and bounded wait for ready
  task automatic prog(input logic [1:0] op, input logic [8:0] a, input logic wd,
                      input logic [7:0] d, input logic busy);
    logic [7:0] s;
    bit         ok;
    fw_u.frame(op, a);
    if (wd)
      fw_u.data_out(d);
    fw_u.deselect();
    fw_u.rd(`SMP_OFFSET, `SMP_BANK, s);
    chk1(s[7], 1'b1);
    fw_u.pw(1'b1, 1'b0, 1'b0);
    fw_u.rd(`SMP_OFFSET, `SMP_BANK, s);
    chk1(s[7], ~busy);
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++)
    begin
      fw_u.rd(`SMP_OFFSET, `SMP_BANK, s);
      ok = (s[7] === 1'b1);
    end
    if (!ok)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
    fw_u.deselect();
  endtask

  // read two consecutive words after the dummy bit
  task automatic rdw(input logic [8:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0]  s;
    logic [15:0] w;
    fw_u.frame(`OP_READ, a);
    fw_u.rd(`SMP_OFFSET, `SMP_BANK, s);
    chk1(s[7], 1'b0);
    for (int i = 15; i >= 0; i--)
    begin
      fw_u.bit_out(1'b0);
      fw_u.rd(`SMP_OFFSET, `SMP_BANK, s);
      w[i] = s[7];
    end
    chk(w[15:8], e0);
    chk(w[7:0], e1);
    fw_u.deselect();
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    fw_u.rd(`SMP_OFFSET, `SMP_BANK, v);
    chk(v, `SMP_RESET);
    fw_u.rd(`SMP_OFFSET, 1'b0, v);
    chk(v, 8'h00);
    fw_u.rd(8'h41, `SMP_BANK, v);
    chk(v, 8'h00);
    fw_u.pw(1'b0, 1'b1, 1'b1);
    fw_u.rd(`SMP_OFFSET, `SMP_BANK, v);
    chk(v, 8'hE0);
    fw_u.deselect();
    prog(`OP_WRITE, 9'h005, 1'b1, 8'h3C, 1'b0);
    prog(`OP_EXT, {`SUB_ENABLE, 7'h00}, 1'b0, 8'h00, 1'b0);
    prog(`OP_WRITE, 9'h105, 1'b1, 8'hA5, 1'b1);
    prog(`OP_WRITE, 9'h006, 1'b1, 8'h5A, 1'b1);
    rdw(9'h005, 8'hA5, 8'h5A);
    prog(`OP_ERASE, 9'h006, 1'b0, 8'h00, 1'b1);
    rdw(9'h005, 8'hA5, 8'hFF);
    prog(`OP_EXT, {`SUB_DISABLE, 7'h00}, 1'b0, 8'h00, 1'b0);
    prog(`OP_WRITE, 9'h005, 1'b1, 8'h00, 1'b0);
    prog(`OP_ERASE, 9'h005, 1'b0, 8'h00, 1'b0);
    prog(`OP_EXT, {`SUB_ERASE_ALL, 7'h00}, 1'b0, 8'h00, 1'b0);
    prog(`OP_EXT, {`SUB_WRITE_ALL, 7'h00}, 1'b1, 8'h00, 1'b0);
    rdw(9'h005, 8'hA5, 8'hFF);
    prog(`OP_EXT, {`SUB_ENABLE, 7'h00}, 1'b0, 8'h00, 1'b0);
    prog(`OP_EXT, {`SUB_ERASE_ALL, 7'h00}, 1'b0, 8'h00, 1'b1);
    rdw(9'h0FF, 8'hFF, 8'hFF);
    prog(`OP_EXT, {`SUB_WRITE_ALL, 7'h00}, 1'b1, 8'h3C, 1'b1);
    rdw(9'h0FF, 8'h3C, 8'h3C);
    end_of_test();
  end
endmodule
`default_nettype wire
